// [verilog/sfrs_pkg.sv]
`default_nettype none

package sfrs_pkg;

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;

    // ------------------------------------------------------------
    // reset timing, in their own units
    // ------------------------------------------------------------
    localparam int POWER_UP_DELAY_US          = 300;
    localparam int RESET_HOLD_PERIOD_US       = 35;
    localparam int RESET_LOW_PULSE_WIDTH_NS   = 200;
    localparam int RESET_HIGH_SETUP_NS        = 50;
    localparam int POST_RESET_SELECT_HOLD_NS  = 50;

    // ------------------------------------------------------------
    // derived cycle counts (longest rounds down, least rounds up)
    // ------------------------------------------------------------
    localparam int POWER_UP_CYC   = (POWER_UP_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int HOLD_CYC       = (RESET_HOLD_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int PULSE_CYC_RAW  = (RESET_LOW_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int PULSE_CYC      = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
    localparam int PIN_LAT_CYC    = 3;  // sync stages plus edge detect, taken off the timers
    localparam int CNT_W          = 12;
    localparam int PULSE_W        = 4;

    // ------------------------------------------------------------
    // sequencer states, gray along the usual path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SFRS_POR     = 3'h0,
        SFRS_WAIT_HI = 3'h1,
        SFRS_READY   = 3'h3,
        SFRS_WARM    = 3'h2,
        SFRS_FULL    = 3'h6
    } sfrs_state_t;

    // status bundle to the device core
    typedef struct packed {
        logic in_reset;
        logic cmd_enable;
        logic abort;
        logic out_tristate;
        logic active;
        logic standby;
    } sfrs_status_t;

endpackage

`default_nettype wire

// [verilog/sfrs_sequencer.sv]
// Overview of operation
// (RL1) stay in power-on reset until the power-up delay elapses after supply good
// (RL2) power-up delay is at most 300 microseconds
// (RL3) host keeps select high and sends nothing during power-up
// (RL4) reset pin is ignored during power-on reset
// (RL5) reset still low at power-up end keeps device in reset; host waits 50 ns
// (RL6) host holds reset high 50 ns after a reset ends before pulling low
// (RL7) falling reset pin runs short reset finishing within 35 microseconds
// (RL8) if power-on reset failed, falling reset runs the full power-up delay
// (RL9) reset low 200 ns aborts work, tri-states outputs, ignores commands; abort is raised in SFRS_WARM only, not in SFRS_FULL
// (RL10) host raises select during hold, lowers it 50 ns after reset high
// (RL11) host makes pulse width plus select hold at least the hold period
// (RL12) host limits serial clock per command type
// (RL13) host keeps select high 10 ns after reads, 50 ns after program/erase
// (RL14) active while select low; when high, finish pending work then standby
// (RL15) timer from falling reset measures hold period and blocks commands
`timescale 1ns/1ps
`default_nettype none

module sfrs_sequencer #(
    parameter int POWER_UP_CYCLES = sfrs_pkg::POWER_UP_CYC
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               supply_good,
    input  wire logic               por_ok,
    input  wire logic               reset_pin_n,
    input  wire logic               select_n,
    input  wire logic               op_busy,
    output var  sfrs_pkg::sfrs_status_t status
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg, rst_sync_next;
    logic [1:0] sel_sync_reg, sel_sync_next;
    logic [1:0] sup_sync_reg, sup_sync_next;
    logic       rst_prev_reg, rst_prev_next;

    // two stages each, only the second stage is read
    always_comb begin
        rst_sync_next = {rst_sync_reg[0], reset_pin_n};
        sel_sync_next = {sel_sync_reg[0], select_n};
        sup_sync_next = {sup_sync_reg[0], supply_good};
        rst_prev_next = rst_sync_reg[1];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rst_sync_reg <= 2'h3;
            sel_sync_reg <= 2'h3;
            sup_sync_reg <= 2'h0;
            rst_prev_reg <= 1'b1;
        end else begin
            rst_sync_reg <= rst_sync_next;
            sel_sync_reg <= sel_sync_next;
            sup_sync_reg <= sup_sync_next;
            rst_prev_reg <= rst_prev_next;
        end
    end

    logic rst_hi;
    logic rst_fall;
    logic sel_low;
    logic sup_ok;
    assign rst_hi   = rst_sync_reg[1];
    assign rst_fall = rst_prev_reg & ~rst_sync_reg[1];
    assign sel_low  = ~sel_sync_reg[1];
    assign sup_ok   = sup_sync_reg[1];

    // ------------------------------------------------------------
    // sequencer state and timers
    // ------------------------------------------------------------
    sfrs_pkg::sfrs_state_t        state_reg, state_next;
    logic [15:0]                  tmr_reg, tmr_next;
    logic [sfrs_pkg::PULSE_W-1:0] low_reg, low_next;
    logic                         por_good_reg, por_good_next;

    // both timers end early by the input latency so the totals stay in bound
    localparam logic [15:0] PU_LAST   = 16'(POWER_UP_CYCLES - 1 - sfrs_pkg::PIN_LAT_CYC);
    localparam logic [15:0] HOLD_LAST = 16'(sfrs_pkg::HOLD_CYC - 1 - sfrs_pkg::PIN_LAT_CYC);
    localparam logic [sfrs_pkg::PULSE_W-1:0] PULSE_LAST =
        sfrs_pkg::PULSE_W'(sfrs_pkg::PULSE_CYC - 1);

    // next state, power-up and hold timers, low-pulse counter
    always_comb begin
        state_next    = state_reg;
        tmr_next      = tmr_reg;
        por_good_next = por_good_reg;
        low_next      = rst_hi ? '0 :
                        (low_reg == PULSE_LAST ? low_reg : low_reg + 1'b1);
        unique case (state_reg)
            sfrs_pkg::SFRS_POR, sfrs_pkg::SFRS_FULL: begin
                // reset pin plays no part while power-up runs (see RL4)
                if (!sup_ok) begin
                    tmr_next = '0;
                end else if (tmr_reg == PU_LAST) begin // see RL1, see RL2, see RL8
                    tmr_next      = '0;
                    por_good_next = por_ok;
                    state_next    = rst_hi ? sfrs_pkg::SFRS_READY
                                           : sfrs_pkg::SFRS_WAIT_HI; // see RL5
                end else begin
                    tmr_next = tmr_reg + 16'h0001;
                end
            end
            sfrs_pkg::SFRS_WAIT_HI: begin
                if (rst_hi) state_next = sfrs_pkg::SFRS_READY; // see RL5
            end
            sfrs_pkg::SFRS_READY: begin
                if (rst_fall) begin
                    tmr_next   = '0;
                    state_next = por_good_reg ? sfrs_pkg::SFRS_WARM
                                              : sfrs_pkg::SFRS_FULL; // see RL7, see RL8
                end
            end
            sfrs_pkg::SFRS_WARM: begin
                // hold timer started at the falling edge (see RL15)
                if (tmr_reg == HOLD_LAST) begin
                    tmr_next   = '0;
                    state_next = rst_hi ? sfrs_pkg::SFRS_READY
                                        : sfrs_pkg::SFRS_WAIT_HI; // see RL7
                end else begin
                    tmr_next = tmr_reg + 16'h0001;
                end
            end
            default: state_next = sfrs_pkg::SFRS_POR;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg    <= sfrs_pkg::SFRS_POR;
            tmr_reg      <= 16'h0000;
            low_reg      <= '0;
            por_good_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            tmr_reg      <= tmr_next;
            low_reg      <= low_next;
            por_good_reg <= por_good_next;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    sfrs_pkg::sfrs_status_t st_next;
    logic                   ready_next;
    logic                   long_low;

    // long_low: pin held low for the minimum pulse width during a warm reset (state SFRS_WARM only)
    always_comb begin
        ready_next = (state_next == sfrs_pkg::SFRS_READY);
        long_low   = (low_next == PULSE_LAST) & ~rst_hi &
                     (state_reg == sfrs_pkg::SFRS_WARM);
        st_next.in_reset     = ~ready_next;                       // see RL1, see RL5
        st_next.cmd_enable   = ready_next & sel_low;              // see RL15
        st_next.abort        = long_low;                          // see RL9
        st_next.out_tristate = ~ready_next | long_low;            // see RL9
        st_next.active       = ready_next & (sel_low | op_busy);  // see RL14
        st_next.standby      = ready_next & ~sel_low & ~op_busy;  // see RL14
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status <= '{in_reset: 1'b1, cmd_enable: 1'b0, abort: 1'b0,
                        out_tristate: 1'b1, active: 1'b0, standby: 1'b0};
        end else begin
            status <= st_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_por_blocks_cmds: assert property (@(posedge clk) disable iff (reset) // see RL1
        (state_reg == sfrs_pkg::SFRS_POR) |=> !status.cmd_enable)
        else $error("command enabled during power-on reset");

    a_pin_ignored_por: assert property (@(posedge clk) disable iff (reset) // see RL4
        (state_reg == sfrs_pkg::SFRS_POR && sup_ok && tmr_reg != PU_LAST)
        |=> state_reg == sfrs_pkg::SFRS_POR)
        else $error("power-on reset left early");

    // pin may rise right after the end, so only the first cycle is fixed
    a_low_at_end: assert property (@(posedge clk) disable iff (reset) // see RL5
        (state_reg == sfrs_pkg::SFRS_POR && tmr_reg == PU_LAST && sup_ok && !rst_hi)
        |=> state_reg == sfrs_pkg::SFRS_WAIT_HI && status.in_reset)
        else $error("reset low at power-up end not held");

    a_powerup_bound: assert property (@(posedge clk) disable iff (reset) // see RL2
        (state_reg inside {sfrs_pkg::SFRS_POR, sfrs_pkg::SFRS_FULL} && sup_ok
         && tmr_reg == PU_LAST)
        |=> state_reg != sfrs_pkg::SFRS_POR && state_reg != sfrs_pkg::SFRS_FULL)
        else $error("power-up delay overran");

    a_wait_release: assert property (@(posedge clk) disable iff (reset) // see RL5
        (state_reg == sfrs_pkg::SFRS_WAIT_HI && rst_hi)
        |=> state_reg == sfrs_pkg::SFRS_READY && !status.in_reset)
        else $error("reset pin high but device still held");

    a_warm_entry: assert property (@(posedge clk) disable iff (reset) // see RL7
        (state_reg == sfrs_pkg::SFRS_READY && rst_fall && por_good_reg)
        |=> state_reg == sfrs_pkg::SFRS_WARM && tmr_reg == 16'h0000)
        else $error("warm reset not started");

    a_full_entry: assert property (@(posedge clk) disable iff (reset) // see RL8
        (state_reg == sfrs_pkg::SFRS_READY && rst_fall && !por_good_reg)
        |=> state_reg == sfrs_pkg::SFRS_FULL)
        else $error("full reset not started after bad power-on");

    a_hold_bound: assert property (@(posedge clk) disable iff (reset) // see RL15
        (state_reg == sfrs_pkg::SFRS_WARM && tmr_reg == HOLD_LAST)
        |=> state_reg != sfrs_pkg::SFRS_WARM)
        else $error("hold period overran");

    a_reset_no_cmds: assert property (@(posedge clk) disable iff (reset) // see RL15
        status.in_reset |-> status.out_tristate && !status.cmd_enable)
        else $error("commands accepted while in reset");

    a_abort_tristate: assert property (@(posedge clk) disable iff (reset) // see RL9
        status.abort |-> status.out_tristate && !status.cmd_enable)
        else $error("abort without tri-state");

    a_select_active: assert property (@(posedge clk) disable iff (reset) // see RL14
        (state_next == sfrs_pkg::SFRS_READY && (sel_low || op_busy))
        |=> status.active && !status.standby)
        else $error("selected or busy but not active");

    a_standby_idle: assert property (@(posedge clk) disable iff (reset) // see RL14
        $rose(status.standby) |-> !status.active && !status.in_reset)
        else $error("standby while active");

endmodule

`default_nettype wire

// [sim/sfrs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host side: drives the reset pin, chip select and serial clock
module sfrs_host_model (
    input  wire logic clk,
    output var  logic reset_pin_n,
    output var  logic select_n,
    output var  logic sclk
);
    // serial clock of 800 ns, far below every per-command ceiling
    localparam int SCLK_HALF_NS = 400;
    // deselected from time zero, no command during power-up
    initial begin
        reset_pin_n = 1'b1;
        select_n    = 1'b1;
        sclk        = 1'b0;
    end
    // serial clock runs only inside a frame and rests low outside it
    always begin
        #SCLK_HALF_NS;
        sclk <= ~select_n & ~sclk;
    end
    // pull reset low, freeing the bus in the same edge
    task automatic pin_low();
        @(posedge clk);
        select_n    <= 1'b1;
        reset_pin_n <= 1'b0;
    endtask
    // release reset, then keep select high past the hold gap
    task automatic pin_high();
        @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // select or deselect; a deselect leaves a gap before the next select
    task automatic sel(input logic v);
        @(posedge clk);
        select_n <= v;
        if (v) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [sim/sfrs_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sfrs_sequencer_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                   clk, reset, supply_good, por_ok, op_busy, chk;
    logic                   reset_pin_n, select_n;
    sfrs_pkg::sfrs_status_t status;
    logic [3:0]             exp_q[$];
    int                     fail_count, num_checks, cyc, w;
    logic [31:0]            rnd;

    sfrs_sequencer #(.POWER_UP_CYCLES(20)) i_dut (.clk(clk), .reset(reset),
        .supply_good(supply_good), .por_ok(por_ok), .reset_pin_n(reset_pin_n),
        .select_n(select_n), .op_busy(op_busy), .status(status));
    sfrs_host_model i_host (.clk(clk), .reset_pin_n(reset_pin_n), .select_n(select_n),
        .sclk());

    // clock of 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // compare one status bit
    task automatic check(input int idx, input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL status bit %0d expected %b seen %b", idx, exp, seen);
        end
    endtask
    // note an expected bit, then flag the monitor
    task automatic expect_bit(input logic [2:0] idx, input logic v);
        @(posedge clk);
        exp_q.push_back({idx, v});
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
    endtask
    // monitor takes the oldest note whenever a result is flagged
    always @(posedge clk) begin
        logic [3:0] n;
        if (chk && exp_q.size() > 0) begin
            n = exp_q.pop_front();
            check(int'(n[3:1]), status[n[3:1]], n[0]);
        end
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            test_done();
        end
    end
    // verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // ------------------------------------------------------------
    // main sequence: bits 5 in_reset 4 cmd_enable 3 abort 2 tristate 1 active 0 standby
    // ------------------------------------------------------------
    initial begin
        {supply_good, por_ok, op_busy, chk} = 4'h0;
        reset = 1'b1;
        rnd = 32'hA0848C12;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        // pin low through power-up end
        i_host.pin_low();
        supply_good <= 1'b1;
        por_ok      <= 1'b1;
        repeat (8) @(posedge clk);
        expect_bit(3'h5, 1'b1);
        expect_bit(3'h2, 1'b1);
        repeat (40) @(posedge clk);
        expect_bit(3'h5, 1'b1);
        i_host.pin_high();
        repeat (6) @(posedge clk);
        expect_bit(3'h5, 1'b0);
        expect_bit(3'h0, 1'b1);
        $display("test 1 done");
        // warm reset with a random pulse width
        rnd = lfsr(rnd);
        w   = 8 + int'(rnd[2:0]);
        i_host.pin_low();
        repeat (4) @(posedge clk);
        expect_bit(3'h5, 1'b1);
        expect_bit(3'h3, 1'b1);
        expect_bit(3'h2, 1'b1);
        repeat (w - 8) @(posedge clk);
        i_host.pin_high();
        repeat (180) @(posedge clk);
        expect_bit(3'h5, 1'b1);
        expect_bit(3'h4, 1'b0);
        repeat (160) @(posedge clk);
        expect_bit(3'h5, 1'b0);
        $display("test 2 done");
        // select, then busy work after deselect
        i_host.sel(1'b0);
        repeat (5) @(posedge clk);
        expect_bit(3'h1, 1'b1);
        expect_bit(3'h4, 1'b1);
        op_busy <= rnd[3] | 1'b1;
        i_host.sel(1'b1);
        repeat (5) @(posedge clk);
        expect_bit(3'h1, 1'b1);
        expect_bit(3'h0, 1'b0);
        op_busy <= 1'b0;
        repeat (3) @(posedge clk);
        expect_bit(3'h0, 1'b1);
        $display("test 3 done");
        // failed power-up: pin glitch ignored, then full reset
        reset       <= 1'b1;
        supply_good <= 1'b0;
        por_ok      <= 1'b0;
        repeat (2) @(posedge clk);
        reset       <= 1'b0;
        supply_good <= 1'b1;
        repeat (6) @(posedge clk);
        i_host.pin_low();
        repeat (3) @(posedge clk);
        i_host.pin_high();
        repeat (28) @(posedge clk);
        expect_bit(3'h5, 1'b0);
        i_host.pin_low();
        por_ok <= 1'b1;
        repeat (2) @(posedge clk);
        i_host.pin_high();
        repeat (6) @(posedge clk);
        expect_bit(3'h5, 1'b1);
        repeat (30) @(posedge clk);
        expect_bit(3'h5, 1'b0);
        $display("test 4 done");
        // selected, then deselected on the edge the pin falls, pin held low past the hold period
        i_host.sel(1'b0);
        repeat (4) @(posedge clk);
        i_host.pin_low();
        repeat (sfrs_pkg::HOLD_CYC + 10) @(posedge clk);
        expect_bit(3'h5, 1'b1);
        expect_bit(3'h3, 1'b0);
        expect_bit(3'h4, 1'b0);
        i_host.pin_high();
        repeat (6) @(posedge clk);
        expect_bit(3'h5, 1'b0);
        expect_bit(3'h2, 1'b0);
        $display("test 5 done");
        test_done();
    end
endmodule
`default_nettype wire
